// *** core/otu_core.sv ***
// otu_core: operand selection, shift, status word and event arbitration
`timescale 1ns/1ns
module otu_core (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// instruction operand request and result
	input wire otu_pkg::otu_opreq_type op_req,
	output otu_pkg::otu_opres_type op_res,
	output logic op_res_valid,
	// bus access seen by the processor
	input wire otu_pkg::otu_busreq_type bus,
	output logic psw_hit,
	// stack pointer update
	input wire otu_pkg::otu_spchk_type sp_chk,
	// completion and trap entry
	input wire otu_pkg::otu_done_type done,
	input wire otu_pkg::otu_entry_type entry,
	// other event sources
	input wire logic mmu_err,
	input wire logic parity_err,
	input wire logic trap_instr,
	input wire logic power_fail,
	input wire logic console_halt,
	// event service
	input wire logic evt_ack,
	output logic [otu_pkg::EV_NUM-1:0] evt_grant,
	output logic evt_valid,
	output logic [3:0] evt_code,
	// processor state
	output logic dbl_halt,
	output logic [15:0] psw
);
	localparam int T = otu_pkg::PSW_T_BIT;
	localparam int N = otu_pkg::EV_NUM;

	// step a register or the program counter by one word
	function automatic logic [15:0] plus_two(input logic [15:0] v);
		return 16'(v + otu_pkg::REG_STEP);
	endfunction

	otu_pkg::otu_opres_type res_q;
	otu_pkg::otu_opres_type res_d;
	logic res_valid_q;
	logic psw_hit_q;
	logic [15:0] psw_q;
	logic [15:0] psw_d;
	logic dbl_q;
	logic [N-1:0] pend_q;
	logic [N-1:0] pend_d;
	logic [N-1:0] ev_set;
	logic [N-1:0] grant;
	logic [1:0] sync1_q;
	logic [1:0] sync2_q;
	otu_pkg::otu_trc_state_type trc_q;
	otu_pkg::otu_trc_state_type trc_d;
	logic trace_set;

	// instruction fields
	wire [15:0] iw = op_req.word;
	wire [2:0] s_mode = iw[11:9];
	wire [2:0] s_reg = iw[8:6];
	wire [2:0] d_mode = iw[5:3];
	wire [2:0] d_reg = iw[2:0];
	wire is_shift = iw[15:9] == otu_pkg::OPC_SHIFT;
	wire is_pair = iw[15:9] == otu_pkg::OPC_SHIFT_PAIR;
	wire is_jump = iw[15:6] == otu_pkg::OPC_JUMP;
	wire is_call = iw[15:9] == otu_pkg::OPC_CALL;
	wire is_move = iw[15:12] == otu_pkg::OPC_MOVE;

	// same register as register-mode source and stepped destination
	wire d_steps = d_mode >= otu_pkg::MODE_AINC && d_mode <= otu_pkg::MODE_ADEC_DEF;
	wire same_reg = s_mode == otu_pkg::MODE_REG && s_reg == d_reg && d_steps;
	wire [15:0] src_sel = same_reg ? op_req.d_pre : op_req.s_val;

	// jump through (R)+
	wire jump_ainc = (is_jump | is_call) & d_mode == otu_pkg::MODE_AINC;

	// move of the program counter through the program counter
	wire pc_dst = d_mode == otu_pkg::MODE_AINC_DEF || d_mode == otu_pkg::MODE_IDX || d_mode == otu_pkg::MODE_IDX_DEF;
	wire move_pc = is_move & s_mode == otu_pkg::MODE_REG & s_reg == otu_pkg::REG_PC & d_reg == otu_pkg::REG_PC & pc_dst;

	// shifter operand: pair {R, R|1} or sign-extended R
	wire [31:0] sh_opnd = is_pair ? {op_req.r_val, op_req.r_odd} : {{16{op_req.r_val[15]}}, op_req.r_val};
	wire [otu_pkg::SHIFT_CW-1:0] sh_cnt = op_req.s_val[otu_pkg::SHIFT_CW-1:0];
	wire [31:0] sh_res;
	wire sh_carry;
	wire shift_c = sh_cnt[otu_pkg::SHIFT_CW-1] ? sh_carry : sh_res[16];

	otu_shifter #(
		.W(32),
		.CW(otu_pkg::SHIFT_CW)
	) u_shift (
		.opnd(sh_opnd),
		.count(sh_cnt),
		.res(sh_res),
		.carry(sh_carry)
	);

	// operand result for the request
	always_comb begin
		res_d = res_q;
		if (op_req.valid) begin
			res_d.src_opnd = src_sel;
			res_d.pc_load = is_jump | is_call;
			res_d.new_pc = jump_ainc ? op_req.d_pre : op_req.ea;
			res_d.reg_wb_en = jump_ainc;
			res_d.reg_wb = plus_two(op_req.d_pre);
			res_d.store_val = move_pc ? plus_two(op_req.pc_val) : src_sel;
			res_d.sh_en = is_shift | is_pair;
			res_d.sh_pair = is_pair;
			res_d.sh_hi = is_pair ? sh_res[31:16] : sh_res[15:0];
			res_d.sh_lo = is_pair ? sh_res[15:0] : op_req.r_odd;
			res_d.sh_c = is_pair ? sh_carry : shift_c;
		end
	end

	// result registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			res_q <= '0;
			res_valid_q <= 1'b0;
		end else begin
			res_q <= res_d;
			res_valid_q <= op_req.valid;
		end
	end

	// bus access classification
	wire psw_sel = bus.addr[15:1] == otu_pkg::PSW_ODD_ADDR[15:1];
	wire psw_wr = bus.valid & bus.wr & psw_sel;
	wire odd_word = bus.valid & ~bus.byte_acc & bus.addr[0];
	wire sp_fault = bus.valid & bus.sp_ref & (bus.addr[0] | bus.nxm);

	// stack overflow check
	wire sp_mode = sp_chk.rnum == otu_pkg::REG_SP && (sp_chk.mode == otu_pkg::MODE_ADEC || sp_chk.mode == otu_pkg::MODE_ADEC_DEF);
	wire sp_when = sp_chk.valid & (sp_mode | sp_chk.call | sp_chk.trap);
	wire stk_ovf = sp_when & (sp_chk.sp < otu_pkg::STACK_LIMIT);

	// completion decode
	wire d_ret_int = done.valid & done.word == otu_pkg::OPC_RET_INT;
	wire d_ret_trap = done.valid & done.word == otu_pkg::OPC_RET_TRAP;

	// trace sequencing at instruction completion
	always_comb begin
		trc_d = trc_q;
		trace_set = 1'b0;
		if (done.valid) begin
			case (trc_q)
				otu_pkg::TR_RUN: begin
					if (d_ret_int) begin
						trace_set = done.new_psw[T];
					end else if (d_ret_trap) begin
						trc_d = otu_pkg::TR_SKIP;
					end else begin
						trace_set = psw_q[T];
					end
				end
				otu_pkg::TR_SKIP: begin
					trace_set = psw_q[T] & ~d_ret_trap & ~d_ret_int;
					if (d_ret_int) begin
						trace_set = done.new_psw[T];
					end
					trc_d = d_ret_trap ? otu_pkg::TR_SKIP : otu_pkg::TR_RUN;
				end
				default: begin
					trc_d = otu_pkg::TR_RUN;
				end
			endcase
		end
	end

	// status word: only entries and returns may touch the trace flag
	always_comb begin
		psw_d = psw_q;
		if (entry.valid) begin
			psw_d = entry.new_psw;
		end else if (d_ret_int | d_ret_trap) begin
			psw_d = done.new_psw;
		end else if (psw_wr) begin
			if (bus.byte_acc & bus.addr[0]) begin
				psw_d[15:8] = bus.wdata[15:8];
			end else if (bus.byte_acc) begin
				psw_d[7:0] = bus.wdata[7:0];
			end else begin
				psw_d = bus.wdata;
			end
			psw_d[T] = psw_q[T];
		end
	end

	// event sources in service order
	assign ev_set[otu_pkg::EV_HALT] = done.valid & done.word == otu_pkg::OPC_HALT;
	assign ev_set[otu_pkg::EV_ODD] = odd_word & ~bus.sp_ref;
	assign ev_set[otu_pkg::EV_MMU] = mmu_err;
	assign ev_set[otu_pkg::EV_TIMEOUT] = bus.valid & bus.nxm & ~bus.sp_ref;
	assign ev_set[otu_pkg::EV_PARITY] = parity_err;
	assign ev_set[otu_pkg::EV_TRAP] = trap_instr;
	assign ev_set[otu_pkg::EV_TRACE] = trace_set;
	assign ev_set[otu_pkg::EV_STKOVF] = stk_ovf;
	assign ev_set[otu_pkg::EV_PWRFAIL] = sync2_q[0];
	assign ev_set[otu_pkg::EV_CONSOLE] = sync2_q[1];

	// a new event wins over the acknowledge of the same bit
	assign pend_d = (pend_q & ~(evt_ack ? grant : '0)) | ev_set;

	otu_prio #(
		.N(N)
	) u_prio (
		.pend(pend_q),
		.grant(grant),
		.any(evt_valid),
		.code(evt_code)
	);

	// state registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			psw_q <= otu_pkg::PSW_RESET;
			trc_q <= otu_pkg::TR_RUN;
			pend_q <= '0;
			dbl_q <= 1'b0;
			psw_hit_q <= 1'b0;
			sync1_q <= 2'h0;
			sync2_q <= 2'h0;
		end else begin
			psw_q <= psw_d;
			trc_q <= trc_d;
			pend_q <= pend_d;
			dbl_q <= dbl_q | sp_fault;
			psw_hit_q <= bus.valid & psw_sel;
			sync1_q <= {console_halt, power_fail};
			sync2_q <= sync1_q;
		end
	end

	// outputs
	assign op_res = res_q;
	assign op_res_valid = res_valid_q;
	assign psw_hit = psw_hit_q;
	assign evt_grant = grant;
	assign dbl_halt = dbl_q;
	assign psw = psw_q;

	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	chk_shift_left: assert property (op_req.valid && is_shift && sh_cnt == 6'h01 |=>
		op_res_valid && op_res.sh_hi == 16'($past(op_req.r_val) << 1))
		else $error("shift by one did not move the register left");
	chk_shift_pair: assert property (op_req.valid && is_pair && sh_cnt == 6'h3F |=>
		op_res.sh_lo == {$past(op_req.r_val[0]), $past(op_req.r_odd[15:1])})
		else $error("pair shift right lost the high-to-low carry");
	chk_src_prestep: assert property (op_req.valid && same_reg |=>
		op_res.src_opnd == $past(op_req.d_pre))
		else $error("stepped register gave a stepped source");
	chk_jump_target: assert property (op_req.valid && jump_ainc |=>
		op_res.pc_load && op_res.new_pc == $past(op_req.d_pre))
		else $error("autoincrement jump took the stepped target");
	chk_jump_step: assert property (op_req.valid && jump_ainc |=>
		op_res.reg_wb_en && op_res.reg_wb == 16'($past(op_req.d_pre) + 16'h0002))
		else $error("autoincrement jump register not advanced by two");
	chk_pc_store: assert property (op_req.valid && move_pc |=>
		op_res.store_val == 16'($past(op_req.pc_val) + 16'h0002))
		else $error("stored program counter is not plus two");
	chk_sp_halt: assert property (sp_fault |=> dbl_halt [*4])
		else $error("stack pointer fault did not hold the halt");
	chk_sp_notrap: assert property (sp_fault |=> !$rose(pend_q[otu_pkg::EV_ODD]))
		else $error("stack pointer fault raised an odd-address trap");
	chk_stack_limit: assert property (sp_chk.valid && sp_chk.call && sp_chk.sp < 16'h0100 |=>
		pend_q[otu_pkg::EV_STKOVF])
		else $error("call below the stack limit raised no overflow");
	chk_stack_ok: assert property (sp_chk.valid && sp_chk.sp >= 16'h0100 && !pend_q[otu_pkg::EV_STKOVF] |=>
		!pend_q[otu_pkg::EV_STKOVF])
		else $error("overflow raised above the stack limit");
	chk_ret_int_trace: assert property (d_ret_int && done.new_psw[T] |=> pend_q[otu_pkg::EV_TRACE])
		else $error("trace not pending right after the interrupt return");
	chk_ret_trap_skip: assert property (d_ret_trap && !pend_q[otu_pkg::EV_TRACE] |=>
		!pend_q[otu_pkg::EV_TRACE] && trc_q == otu_pkg::TR_SKIP)
		else $error("trace taken on the trap return itself");
	chk_psw_odd_byte: assert property (bus.valid && bus.byte_acc && bus.addr == 16'h7FFF |=>
		!$rose(pend_q[otu_pkg::EV_ODD]) && psw_hit)
		else $error("odd status byte access trapped");
	chk_t_locked: assert property (psw_wr && !entry.valid && !d_ret_int && !d_ret_trap |=> $stable(psw_q[T]))
		else $error("direct status write changed the trace flag");
	chk_prio_order: assert property (pend_q[otu_pkg::EV_HALT] |-> evt_grant == 10'h001 && evt_code == 4'h0)
		else $error("halt not granted first");
	chk_prio_trace: assert property (pend_q[otu_pkg::EV_STKOVF] && pend_q[otu_pkg::EV_TRACE] &&
		pend_q[5:0] == 6'h00 |-> evt_grant[otu_pkg::EV_TRACE])
		else $error("overflow served ahead of trace");

	cov_shift_pair: cover property (op_req.valid && is_pair);
	cov_ret_trap_trace: cover property (d_ret_trap ##[1:20] (done.valid && trace_set));
	cov_stk_ovf: cover property (stk_ovf ##1 evt_grant[otu_pkg::EV_STKOVF]);
	cov_dbl_halt: cover property (sp_fault);
endmodule

// *** core/otu_pkg.sv ***
// otu_pkg: constants and carrier types of the operand and trap semantics unit
// How it works
// - opcode 072RSS shifts register R arithmetically by the signed count in the source, positive meaning left.
// - opcode 073RSS does the same shift on the register pair R and R|1 taken as one 32-bit operand.
// - a register-mode source that is also the stepped destination supplies its value from before the step.
// - a jump or subroutine call through (R)+ loads the program counter with the original value of R.
// - a move of the program counter to a location addressed through the program counter writes PC plus 2.
// - an odd or nonexistent address reached through the stack pointer halts as a double bus error, no trap.
// - stack overflow is checked against the fixed limit 400 octal after modes 4 and 5 on the stack pointer, calls and traps.
// - a stack overflow raises the overflow trap, and there is no second red-zone level.
// - a return from interrupt that sets the trace flag takes the trace trap right after it.
// - after a return from trap the next instruction always runs before a newly loaded trace flag traps.
// - a byte access to the odd status byte at 77777 octal raises no trap.
// - a direct write to the status word never changes the trace flag.
// - pending events are served in the order halt, odd address, memory management, time-out, parity, trap, trace, overflow, power fail, console halt.
package otu_pkg;
	localparam logic [6:0] OPC_SHIFT = 7'h3A;
	localparam logic [6:0] OPC_SHIFT_PAIR = 7'h3B;
	localparam logic [6:0] OPC_CALL = 7'h04;
	localparam logic [9:0] OPC_JUMP = 10'h001;
	localparam logic [3:0] OPC_MOVE = 4'h1;
	localparam logic [15:0] OPC_HALT = 16'h0000;
	localparam logic [15:0] OPC_RET_INT = 16'h0002;
	localparam logic [15:0] OPC_RET_TRAP = 16'h0006;
	localparam logic [15:0] REG_STEP = 16'h0002;
	localparam logic [15:0] PC_STORE_OFS = 16'h0002;
	localparam logic [15:0] STACK_LIMIT = 16'h0100;
	localparam logic [15:0] PSW_ODD_ADDR = 16'h7FFF;
	localparam logic [15:0] PSW_RESET = 16'h0000;
	localparam int PSW_T_BIT = 4;
	localparam logic [2:0] MODE_REG = 3'h0;
	localparam logic [2:0] MODE_AINC = 3'h2;
	localparam logic [2:0] MODE_AINC_DEF = 3'h3;
	localparam logic [2:0] MODE_ADEC = 3'h4;
	localparam logic [2:0] MODE_ADEC_DEF = 3'h5;
	localparam logic [2:0] MODE_IDX = 3'h6;
	localparam logic [2:0] MODE_IDX_DEF = 3'h7;
	localparam logic [2:0] REG_SP = 3'h6;
	localparam logic [2:0] REG_PC = 3'h7;
	localparam int SHIFT_CW = 6;
	// event bit positions, lowest index served first
	localparam int EV_HALT = 0;
	localparam int EV_ODD = 1;
	localparam int EV_MMU = 2;
	localparam int EV_TIMEOUT = 3;
	localparam int EV_PARITY = 4;
	localparam int EV_TRAP = 5;
	localparam int EV_TRACE = 6;
	localparam int EV_STKOVF = 7;
	localparam int EV_PWRFAIL = 8;
	localparam int EV_CONSOLE = 9;
	localparam int EV_NUM = 10;

	typedef enum logic [1:0] {
		TR_RUN = 2'b01,
		TR_SKIP = 2'b10
	} otu_trc_state_type;

	// operand request for one decoded instruction
	typedef struct packed {
		logic valid;
		logic [15:0] word;
		logic [15:0] r_val;
		logic [15:0] r_odd;
		logic [15:0] d_pre;
		logic [15:0] s_val;
		logic [15:0] pc_val;
		logic [15:0] ea;
	} otu_opreq_type;

	typedef struct packed {
		logic [15:0] src_opnd;
		logic [15:0] new_pc;
		logic pc_load;
		logic [15:0] reg_wb;
		logic reg_wb_en;
		logic [15:0] store_val;
		logic [15:0] sh_hi;
		logic [15:0] sh_lo;
		logic sh_c;
		logic sh_en;
		logic sh_pair;
	} otu_opres_type;

	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		logic byte_acc;
		logic wr;
		logic [15:0] wdata;
		logic sp_ref;
		logic nxm;
	} otu_busreq_type;

	typedef struct packed {
		logic valid;
		logic [2:0] mode;
		logic [2:0] rnum;
		logic call;
		logic trap;
		logic [15:0] sp;
	} otu_spchk_type;

	typedef struct packed {
		logic valid;
		logic [15:0] word;
		logic [15:0] new_psw;
	} otu_done_type;

	typedef struct packed {
		logic valid;
		logic [15:0] new_psw;
	} otu_entry_type;
endpackage

// *** core/otu_shifter.sv ***
// otu_shifter: signed-count arithmetic shifter with carry out
`timescale 1ns/1ns
module otu_shifter #(
	parameter int W = 32,
	parameter int CW = 6
) (
	// operand and count
	input wire logic [W-1:0] opnd,
	input wire logic [CW-1:0] count,
	// result
	output logic [W-1:0] res,
	output logic carry
);
	if (W < 2 || CW < 2 || (1 << (CW - 1)) > W) begin : g_bad
		$error("otu_shifter: count range exceeds operand width");
	end

	logic left;
	logic [CW-1:0] mag;
	logic [W:0] lsh;
	logic [W:0] rsh;

	// negative count shifts right, sign bit fills from the top
	assign left = ~count[CW-1];
	assign mag = left ? count : CW'(-count);
	assign lsh = {1'b0, opnd} << mag;
	assign rsh = (W + 1)'($signed({opnd, 1'b0}) >>> mag);
	assign res = left ? lsh[W-1:0] : rsh[W:1];
	assign carry = left ? lsh[W] : rsh[0];
endmodule

// *** core/otu_prio.sv ***
// otu_prio: fixed-order event arbiter, lowest index wins
`timescale 1ns/1ns
module otu_prio #(
	parameter int N = 10
) (
	// pending events
	input wire logic [N-1:0] pend,
	// selected event
	output logic [N-1:0] grant,
	output logic any,
	output logic [3:0] code
);
	if (N < 1 || N > 16) begin : g_bad
		$error("otu_prio: event count must be 1 to 16");
	end

	// isolate the lowest set bit
	assign grant = pend & N'(-pend);
	assign any = |pend;

	// binary index of the granted event
	always_comb begin
		code = 4'h0;
		for (int i = 0; i < N; i++) begin
			if (grant[i]) begin
				code = 4'(i);
			end
		end
	end
endmodule

// *** test/otu_bus_model.sv ***
// otu_bus_model: memory and peripherals answering the processor's bus accesses
`timescale 1ns/1ns
module otu_bus_model #(
	parameter logic [15:0] MEM_TOP = 16'h4000
) (
	// clock
	input wire logic clk_sys,
	// access asked for by the bench
	input wire logic go,
	input wire logic [15:0] addr,
	input wire logic byte_acc,
	input wire logic wr,
	input wire logic [15:0] wdata,
	input wire logic sp_ref,
	// access and outcome seen by the unit
	output otu_pkg::otu_busreq_type bus
);
	logic [15:0] last_q = 16'h0000;
	// status word answers at its fixed pair of addresses, memory ends below MEM_TOP
	wire logic psw_sel = addr[15:1] == otu_pkg::PSW_ODD_ADDR[15:1];
	wire logic nxm = !psw_sel && addr >= MEM_TOP;
	// remember the last address so idle lines never repeat it
	always_ff @(posedge clk_sys) begin
		if (go)
			last_q <= addr;
	end
	// released bus carries the inverse of the last value
	assign bus = go ? {1'b1, addr, byte_acc, wr, wdata, sp_ref, nxm} :
		{1'b0, ~last_q, 1'b1, 1'b0, ~last_q, 1'b0, 1'b0};
endmodule

// *** test/tb_top.sv ***
// tb_top: self-checking bench for the operand and trap unit with its bus partner
`timescale 1ns/1ns
module tb_top;
	localparam int WD_CYC = 2000;
	logic clk_sys, rstn, go, b_byte, b_wr, b_sp, evt_ack;
	logic mmu_err, parity_err, trap_instr, power_fail, console_halt;
	logic op_res_valid, psw_hit, evt_valid, dbl_halt, pair;
	logic [15:0] b_addr, b_wdata, psw;
	logic [9:0] evt_grant;
	logic [3:0] evt_code;
	logic [31:0] rnd;
	logic [32:0] e;
	otu_pkg::otu_opreq_type op_req;
	otu_pkg::otu_opres_type op_res;
	otu_pkg::otu_busreq_type bus;
	otu_pkg::otu_spchk_type sp_chk;
	otu_pkg::otu_done_type done;
	otu_pkg::otu_entry_type entry;
	int errors, compares, pend;
	int exp_q[$];

	otu_bus_model i_otu_bus_model (.clk_sys(clk_sys), .go(go), .addr(b_addr), .byte_acc(b_byte), .wr(b_wr),
		.wdata(b_wdata), .sp_ref(b_sp), .bus(bus));
	otu_core i_otu_core (.clk_sys(clk_sys), .rstn(rstn), .op_req(op_req), .op_res(op_res), .op_res_valid(op_res_valid),
		.bus(bus), .psw_hit(psw_hit), .sp_chk(sp_chk), .done(done), .entry(entry), .mmu_err(mmu_err),
		.parity_err(parity_err), .trap_instr(trap_instr), .power_fail(power_fail), .console_halt(console_halt),
		.evt_ack(evt_ack), .evt_grant(evt_grant), .evt_valid(evt_valid), .evt_code(evt_code), .dbl_halt(dbl_halt),
		.psw(psw));

	// 50 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// reference shift: negative count goes right with sign fill, carry in the top bit
	function automatic logic [32:0] ref_shift(logic [31:0] v, logic [5:0] c, int w);
		logic signed [63:0] x;
		logic cy;
		x = (w == 16) ? {{48{v[15]}}, v[15:0]} : {{32{v[31]}}, v};
		if (c[5]) begin
			x = x >>> (7'd63 - {1'b0, c});
			cy = x[0];
			x = x >>> 1;
		end else begin
			x = x <<< c;
			cy = (w == 16) ? x[16] : x[32];
		end
		return {cy, x[31:0]};
	endfunction

	task automatic chk(logic ok, string m);
		compares++;
		if (!ok) begin
			errors++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask

	task automatic print_verdict();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask

	// drop every request and pulse, then let one edge pass
	task automatic idle();
		op_req = '0;
		sp_chk = '0;
		done = '0;
		entry = '0;
		go = 1'b0;
		{mmu_err, parity_err, trap_instr, power_fail, console_halt} = 5'h00;
		cyc(1);
	endtask

	task automatic rst();
		rstn = 1'b0;
		cyc(4);
		rstn = 1'b1;
		cyc(1);
		chk(psw === 16'h0000 && dbl_halt === 1'b0 && evt_valid === 1'b0 && op_res_valid === 1'b0, "reset state");
	endtask

	// one operand request, answer one cycle later; valid stays up for back-to-back use
	task automatic op(logic [15:0] w, r, ro, dp, s, pc);
		op_req = '{1'b1, w, r, ro, dp, s, pc, 16'h0000};
		cyc(1);
		chk(op_res_valid === 1'b1, "no operand result");
	endtask

	task automatic acc(logic [15:0] a, logic by, wr, sp, logic [15:0] d);
		go = 1'b1;
		b_addr = a;
		b_byte = by;
		b_wr = wr;
		b_sp = sp;
		b_wdata = d;
		cyc(1);
	endtask

	task automatic fin(logic [15:0] w, p);
		done = '{1'b1, w, p};
		cyc(1);
	endtask

	// serve the model's pending events, lowest index first, ack held high
	task automatic drain();
		int k;
		for (int i = 0; i < 10; i++)
			if (pend[i])
				exp_q.push_back(i);
		while (exp_q.size() > 0) begin
			k = exp_q.pop_front();
			chk(evt_valid === 1'b1 && evt_code === k[3:0] && evt_grant === 10'h001 << k, "event order");
			evt_ack = 1'b1;
			cyc(1);
		end
		evt_ack = 1'b0;
		pend = 0;
		chk(evt_valid === 1'b0, "event left pending");
	endtask

	task automatic spc(logic [2:0] m, r, logic cl, logic [15:0] sp, int ex);
		sp_chk = '{1'b1, m, r, cl, 1'b0, sp};
		cyc(1);
		sp_chk.valid = 1'b0;
		cyc(1);
		pend = ex << otu_pkg::EV_STKOVF;
		drain();
	endtask

	// main sequence
	initial begin
		rnd = 32'hb9a0;
		errors = 0;
		compares = 0;
		pend = 0;
		evt_ack = 1'b0;
		rstn = 1'b0;
		{b_addr, b_wdata, b_byte, b_wr, b_sp} = 35'h0;
		idle();
		rst();
		// shifts: worked example, then random counts in both directions
		op(16'h7403, 16'h029C, 16'h5555, 16'h0000, 16'h0003, 16'h0000);
		chk(op_res.sh_hi === 16'h14E0 && op_res.sh_en === 1'b1, "shift example");
		op(16'h7401, 16'h8001, 16'h5555, 16'h0000, 16'h0001, 16'h0000);
		chk(op_res.sh_hi === 16'h0002 && op_res.sh_c === 1'b1, "shift left by one");
		op(16'h7600, 16'h0001, 16'h0002, 16'h0000, 16'h003F, 16'h0000);
		chk({op_res.sh_hi, op_res.sh_lo} === 32'h00008001 && op_res.sh_c === 1'b0, "pair right by one");
		for (int i = 0; i < 24; i++) begin
			rnd = lfsr(lfsr(rnd));
			pair = rnd[9];
			e = ref_shift(pair ? rnd : {16'h0000, rnd[31:16]}, rnd[5:0], pair ? 32 : 16);
			op({pair ? otu_pkg::OPC_SHIFT_PAIR : otu_pkg::OPC_SHIFT, rnd[8:7], 1'b0, rnd[5:0]}, rnd[31:16], rnd[15:0],
				16'h0000, {10'h000, rnd[5:0]}, 16'h0000);
			chk(op_res.sh_en === 1'b1 && op_res.sh_pair === pair, "shift kind");
			chk(pair ? {op_res.sh_hi, op_res.sh_lo} === e[31:0] : op_res.sh_hi === e[15:0], "shift result");
			chk(op_res.sh_c === e[32] || rnd[5:0] == 6'h00, "shift carry");
		end
		// register source reused as stepped destination in modes 2 to 5
		for (int m = 2; m < 6; m++) begin
			op({10'h041, m[2:0], 3'h1}, 16'h2468, 16'h0000, 16'h2468, 16'h246A, 16'h0000);
			chk(op_res.src_opnd === 16'h2468, "same register source");
		end
		// jump and call through (R)+, then program counter stores
		op(16'h0052, 16'h0000, 16'h0000, 16'h1230, 16'h0000, 16'h0400);
		chk(op_res.pc_load === 1'b1 && op_res.new_pc === 16'h1230, "jump target");
		chk(op_res.reg_wb_en === 1'b1 && op_res.reg_wb === 16'h1232, "jump step");
		op(16'h0952, 16'h0000, 16'h0000, 16'h3334, 16'h0000, 16'h0400);
		chk(op_res.pc_load === 1'b1 && op_res.new_pc === 16'h3334, "call target");
		for (int m = 0; m < 2; m++) begin
			op(m ? 16'h11F7 : 16'h11DF, 16'h0500, 16'h0000, 16'h0500, 16'h0000, 16'h0500);
			chk(op_res.store_val === 16'h0502, "stored pc");
		end
		idle();
		// status word: odd byte write, then a word write that must not touch the trace flag
		acc(otu_pkg::PSW_ODD_ADDR, 1'b1, 1'b1, 1'b0, 16'hAB00);
		chk(psw === 16'hAB00 && psw_hit === 1'b1 && evt_valid === 1'b0, "odd status byte");
		acc(16'h7FFE, 1'b0, 1'b1, 1'b0, 16'h00FF);
		chk(psw === 16'h00EF, "trace flag write");
		idle();
		// trace after return from interrupt, then one instruction of grace after return from trap
		fin(otu_pkg::OPC_RET_INT, 16'h0010);
		chk(evt_valid === 1'b1 && evt_code === 4'h6, "trace after interrupt return");
		idle();
		pend = 1 << otu_pkg::EV_TRACE;
		drain();
		fin(otu_pkg::OPC_RET_TRAP, 16'h0010);
		chk(evt_valid === 1'b0, "trace too early after trap return");
		fin(16'h1083, 16'h0000);
		chk(evt_valid === 1'b1 && evt_code === 4'h6, "trace after next instruction");
		idle();
		pend = 1 << otu_pkg::EV_TRACE;
		drain();
		entry = '{1'b1, 16'h00F0};
		cyc(1);
		chk(psw === 16'h00F0, "entry loads the trace flag");
		// all event sources together with trace armed, a timed-out access right behind
		done = '{1'b1, otu_pkg::OPC_HALT, 16'h0000};
		{mmu_err, parity_err, trap_instr, power_fail, console_halt} = 5'h1F;
		sp_chk = '{1'b1, 3'h0, 3'h0, 1'b0, 1'b1, 16'h00F0};
		acc(16'h1001, 1'b0, 1'b0, 1'b0, 16'h0000);
		acc(16'h8000, 1'b0, 1'b0, 1'b0, 16'h0000);
		idle();
		cyc(4);
		pend = 10'h3FF;
		drain();
		// stack limit table, boundary included
		spc(otu_pkg::MODE_ADEC, otu_pkg::REG_SP, 1'b0, 16'h00FE, 1);
		spc(otu_pkg::MODE_ADEC_DEF, otu_pkg::REG_SP, 1'b0, 16'h00FE, 1);
		spc(otu_pkg::MODE_ADEC, otu_pkg::REG_SP, 1'b0, otu_pkg::STACK_LIMIT, 0);
		spc(otu_pkg::MODE_AINC, otu_pkg::REG_SP, 1'b0, 16'h0000, 0);
		spc(otu_pkg::MODE_ADEC, 3'h5, 1'b0, 16'h0000, 0);
		spc(otu_pkg::MODE_REG, 3'h0, 1'b1, 16'h0000, 1);
		// stack pointer faults halt instead of trapping
		acc(16'h00FF, 1'b0, 1'b0, 1'b1, 16'h0000);
		chk(dbl_halt === 1'b1 && evt_valid === 1'b0, "stack odd address");
		idle();
		rst();
		acc(16'h9000, 1'b0, 1'b1, 1'b1, 16'h1234);
		chk(dbl_halt === 1'b1 && evt_valid === 1'b0, "stack missing memory");
		idle();
		print_verdict();
	end

	// cut a hang short
	initial begin
		repeat (WD_CYC) @(posedge clk_sys);
		errors++;
		print_verdict();
	end
endmodule
